// ---- bench/giocfg_chk.sv ----
// Purpose: Concurrent checks on the configuration register block ports
// Assumes: Single clock, synchronous active-high reset
// Notes:   Attached by bind
`timescale 1ns/1ns
module giocfg_chk (
	input wire logic        clk_sys, reset, psel, penable, pwrite, generic_io_pin_i, // Clock, reset, bus, pin
	input wire logic        generic_io_pin_o, generic_io_pin_oe, cellbus_output_enable_pin, // Pin, enable
	input wire logic        rx_bus_oe, tx_bus_oe, wide_bus_alt_pins, // Gate results
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, prdata, // Data
	input wire logic [1:0]  rx_bus_width, tx_bus_width, // Widths
	input wire logic [15:0] config_out // Stored word
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence acc_s; psel && penable && paddr == 12'h008; endsequence
	sequence wr_s; acc_s ##0 pwrite; endsequence
	sequence rd_s; acc_s ##0 !pwrite; endsequence
	chk_dir_enable: assert property (generic_io_pin_oe == config_out[12]) else $error("pin enable wrong");
	chk_pin_read: assert property (rd_s ##0 !config_out[12] |-> prdata[13] == $past(generic_io_pin_i))
		else $error("pin read wrong");
	chk_pin_drive: assert property (generic_io_pin_o == (config_out[12] & config_out[13]))
		else $error("pin level wrong");
	chk_val_store: assert property (wr_s ##0 config_out[12] |=> config_out[13:10] == $past(pwdata[13:10]))
		else $error("write not stored");
	chk_rx_gate: assert property (rx_bus_oe == (config_out[11] | (cellbus_output_enable_pin & config_out[4])))
		else $error("rx gate wrong");
	chk_tx_gate: assert property (tx_bus_oe == (config_out[10] | (cellbus_output_enable_pin & config_out[4])))
		else $error("tx gate wrong");
	chk_wide_sel: assert property (wide_bus_alt_pins == (config_out[7] & (rx_bus_width == 2'h3 || tx_bus_width == 2'h3)))
		else $error("wide select wrong");
	chk_unused_zero: assert property (config_out[15:14] == 2'h0 && config_out[9:8] == 2'h0)
		else $error("unused bits set");
	chk_reset_zero: assert property ($fell(reset) |-> config_out == 16'h0000) else $error("reset value wrong");
endmodule
bind giocfg_top giocfg_chk u_chk (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.generic_io_pin_i(generic_io_pin_i), .generic_io_pin_o(generic_io_pin_o), .generic_io_pin_oe(generic_io_pin_oe),
	.cellbus_output_enable_pin(cellbus_output_enable_pin), .rx_bus_oe(rx_bus_oe), .tx_bus_oe(tx_bus_oe),
	.wide_bus_alt_pins(wide_bus_alt_pins), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.rx_bus_width(rx_bus_width), .tx_bus_width(tx_bus_width), .config_out(config_out));

// ---- bench/test_global_io_config_bits.sv ----
// Purpose: Self-checking bench with a reference model of the configuration word
// Assumes: Zero or more wait states, APB master in the bench
// Notes:   Random data, addresses, pin and width inputs from a fixed seed
`timescale 1ns/1ns
module test_global_io_config_bits;
	import giocfg_pkg::*;
	logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pin_i = 0, en_pin = 0;
	logic        pready, pslverr, err, pin_o, pin_oe, rx_oe, tx_oe, wide;
	logic [11:0] paddr = 12'h000, a;
	logic [31:0] pwdata = 32'h0, prdata, rd, r, d;
	logic [1:0]  rxw = 2'h0, txw = 2'h0;
	logic [15:0] cfg, m = 16'h0, e;
	int          errors = 0, compares = 0, cyc = 0;
	giocfg_top uut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .generic_io_pin_i(pin_i),
		.generic_io_pin_o(pin_o), .generic_io_pin_oe(pin_oe), .cellbus_output_enable_pin(en_pin),
		.rx_bus_width(rxw), .tx_bus_width(txw), .rx_bus_oe(rx_oe), .tx_bus_oe(tx_oe), .wide_bus_alt_pins(wide),
		.config_out(cfg));
	initial forever #2 clk_sys = ~clk_sys;
	task close_out();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors = errors + 1;
			close_out();
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	initial begin
		void'($urandom(32));
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, GIOCFG_GOC_ADDR, 32'h0);
		check(rd, 32'h0);
		// Cell-bus setup written first, enable bit set only afterwards
		apb(1'b1, GIOCFG_GOC_ADDR, 32'h0000_0020);
		m = 16'h0020;
		en_pin <= 1'b1;
		apb(1'b1, GIOCFG_GOC_ADDR, 32'h0000_0030);
		m = 16'h0030;
		check({31'h0, rx_oe}, {31'h0, en_pin & m[4]});
		check({31'h0, pready}, 32'h0000_0001);
		for (int i = 0; i < 80; i++) begin
			r = $urandom;
			d = $urandom;
			pin_i <= r[20];
			en_pin <= r[21];
			rxw <= r[23:22];
			txw <= r[25:24];
			a = (r[27:26] == 2'h0) ? 12'h00c : GIOCFG_GOC_ADDR;
			apb(1'b1, a, d);
			if (a == GIOCFG_GOC_ADDR) m = (d[15:0] & 16'h1cff) | ((m[12] ? d[15:0] : m) & 16'h2000);
			check({31'h0, err}, {31'h0, a != GIOCFG_GOC_ADDR});
			apb(1'b0, a, 32'h0);
			e = m;
			if (!m[12]) e[13] = pin_i;
			check(rd, (a == GIOCFG_GOC_ADDR) ? {16'h0, e} : 32'h0);
			check({cfg & 16'hdfff, 11'h0, pin_oe, pin_o, rx_oe, tx_oe, wide}, {m & 16'hdfff, 11'h0, m[12], m[12] & m[13],
				m[11] | (en_pin & m[4]), m[10] | (en_pin & m[4]), m[7] & (rxw == 2'h3 || txw == 2'h3)});
		end
		close_out();
	end
endmodule

// ---- pkg/giocfg_gate_if.sv ----
// Purpose: Carries configuration bits and gate results between the register file and the gating logic
// Assumes: Single clock domain
// Notes:   Register side drives config, gate side drives enables
`timescale 1ns/1ns
interface giocfg_gate_if;
	logic       rx_output_gate_bypass;
	logic       tx_output_gate_bypass;
	logic       cellbus_output_enable_bit;
	logic       cellbus_output_enable_pin;
	logic       wide_bus_pin_select;
	logic [1:0] rx_bus_width;
	logic [1:0] tx_bus_width;
	logic       rx_oe;
	logic       tx_oe;
	logic       wide_alt_pins;
	modport regs (output rx_output_gate_bypass, output tx_output_gate_bypass,
		output cellbus_output_enable_bit, output cellbus_output_enable_pin,
		output wide_bus_pin_select, output rx_bus_width, output tx_bus_width,
		input rx_oe, input tx_oe, input wide_alt_pins);
	modport gate (input rx_output_gate_bypass, input tx_output_gate_bypass,
		input cellbus_output_enable_bit, input cellbus_output_enable_pin,
		input wide_bus_pin_select, input rx_bus_width, input tx_bus_width,
		output rx_oe, output tx_oe, output wide_alt_pins);
endinterface

// ---- pkg/giocfg_pkg.sv ----
// Purpose: Shared constants and types for the global I/O configuration register block
// Assumes: APB slave, 32-bit data, 16-bit register in the low bits
// Notes:   Field positions of the global operational configuration word
package giocfg_pkg;
	localparam logic [11:0] GIOCFG_GOC_ADDR    = 12'h008;
	localparam int          GIOCFG_REG_W       = 16;
	localparam int          GIOCFG_BIT_GPVAL   = 13;
	localparam int          GIOCFG_BIT_GPDIR   = 12;
	localparam int          GIOCFG_BIT_RXBYP   = 11;
	localparam int          GIOCFG_BIT_TXBYP   = 10;
	localparam int          GIOCFG_BIT_WIDESEL = 7;
	localparam int          GIOCFG_BIT_OEN     = 4;
	localparam logic [1:0]  GIOCFG_WIDTH_64    = 2'h3;
	localparam logic [15:0] GIOCFG_RW_MASK     = 16'h3cff;
	localparam logic [15:0] GIOCFG_RESET_VAL   = 16'h0000;
	localparam logic [31:0] GIOCFG_ZERO32      = 32'h0000_0000;
endpackage

// ---- src/giocfg_gate.sv ----
// Purpose: Cell-bus output gating and wide-bus pin selection
// Assumes: Inputs synchronous to clk_sys
// Notes:   Purely combinational
`timescale 1ns/1ns
module giocfg_gate
	import giocfg_pkg::*;
(
	giocfg_gate_if.gate g // Configuration in, enables out
);
	import giocfg_pkg::*;

	logic en_ok;

	always_comb begin
		en_ok = g.cellbus_output_enable_pin & g.cellbus_output_enable_bit; // see RULE10
		g.rx_oe = g.rx_output_gate_bypass | en_ok; // see RULE5 see RULE6
		g.tx_oe = g.tx_output_gate_bypass | en_ok; // see RULE7
		g.wide_alt_pins = g.wide_bus_pin_select &
			((g.rx_bus_width == GIOCFG_WIDTH_64) | (g.tx_bus_width == GIOCFG_WIDTH_64)); // see RULE8
	end
endmodule

// ---- src/giocfg_top.sv ----
// Purpose: Global operational configuration register with generic pin and cell-bus gating controls
// Assumes: APB slave, synchronous active-high reset, inputs synchronous to clk_sys
// Notes:   Bus widths arrive from the bus configuration registers elsewhere in the device
//
// Overview of operation
// RULE1 - Direction bit 0 makes generic pin input, 1 makes it output.
// RULE2 - As input, value bit is read-only and reads the pin level.
// RULE3 - As output, value bit is writable and sets pin level; 0 drives low.
// RULE4 - As output, writing 1 to value bit drives the pin high.
// RULE5 - Without rx bypass, rx outputs tristate if enable pin or enable bit low.
// RULE6 - With rx bypass set, rx outputs stay driven regardless of enables.
// RULE7 - Without tx bypass, tx outputs tristate if enable pin or enable bit low.
// RULE8 - Wide pin select matters only when a bus width field selects 64 bits.
// RULE9 - Direction, value, bypass and wide select bits reset to 0; 15:14, 9:8 unused.
// RULE10 - Enable bit 0 holds cell-bus outputs high impedance; 1 operates normally.
// RULE11 - Software configures the cell bus fully before setting the enable bit.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module giocfg_top
	import giocfg_pkg::*;
(
	input  wire logic        clk_sys,                   // System clock 250 MHz
	input  wire logic        reset,                     // Synchronous active-high reset
	input  wire logic        psel,                      // APB select
	input  wire logic        penable,                   // APB enable
	input  wire logic        pwrite,                    // APB write
	input  wire logic [11:0] paddr,                     // APB byte address
	input  wire logic [31:0] pwdata,                    // APB write data
	output logic      [31:0] prdata,                    // APB read data
	output logic             pready,                    // APB ready
	output logic             pslverr,                   // APB error, unmapped address
	input  wire logic        generic_io_pin_i,          // Generic pin level in
	output logic             generic_io_pin_o,          // Generic pin level out
	output logic             generic_io_pin_oe,         // Generic pin drive enable
	input  wire logic        cellbus_output_enable_pin, // External cell-bus enable pin
	input  wire logic [1:0]  rx_bus_width,              // Receive bus width field
	input  wire logic [1:0]  tx_bus_width,              // Transmit bus width field
	output logic             rx_bus_oe,                 // Receive cell-bus output enable
	output logic             tx_bus_oe,                 // Transmit cell-bus output enable
	output logic             wide_bus_alt_pins,         // Extra 32 lines on alternate pins
	output logic [15:0]      config_out                 // Stored configuration word
);
	import giocfg_pkg::*;

	typedef struct packed {
		logic [15:0] cfg;
		logic        pin_val;
		logic [31:0] rdata;
	} giocfg_state_t;

	giocfg_state_t st_reg;
	giocfg_state_t st_next;
	giocfg_gate_if gif ();

	logic        hit;
	logic        wr;
	logic        rd;
	logic [15:0] wv;
	logic [15:0] rv;

	giocfg_gate u_gate (
		.g (gif.gate)
	);

	assign gif.rx_output_gate_bypass     = st_reg.cfg[GIOCFG_BIT_RXBYP];
	assign gif.tx_output_gate_bypass     = st_reg.cfg[GIOCFG_BIT_TXBYP];
	assign gif.cellbus_output_enable_bit = st_reg.cfg[GIOCFG_BIT_OEN];
	assign gif.cellbus_output_enable_pin = cellbus_output_enable_pin;
	assign gif.wide_bus_pin_select       = st_reg.cfg[GIOCFG_BIT_WIDESEL];
	assign gif.rx_bus_width              = rx_bus_width;
	assign gif.tx_bus_width              = tx_bus_width;

	always_comb begin
		hit = (paddr == GIOCFG_GOC_ADDR);
		wr  = psel & penable & pwrite & hit;
		rd  = psel & penable & ~pwrite & hit;
		wv  = pwdata[GIOCFG_REG_W-1:0] & GIOCFG_RW_MASK; // see RULE9
		rv  = st_reg.cfg;
		// Value bit reads the pin when input, the stored level when output
		if (st_reg.cfg[GIOCFG_BIT_GPDIR]) begin
			rv[GIOCFG_BIT_GPVAL] = st_reg.cfg[GIOCFG_BIT_GPVAL];
		end else begin
			rv[GIOCFG_BIT_GPVAL] = st_reg.pin_val; // see RULE2
		end
		st_next         = st_reg;
		st_next.pin_val = generic_io_pin_i;
		if (wr) begin
			st_next.cfg = wv;
			// Value bit is writable only while the pin is an output
			if (st_reg.cfg[GIOCFG_BIT_GPDIR]) begin
				st_next.cfg[GIOCFG_BIT_GPVAL] = pwdata[GIOCFG_BIT_GPVAL]; // see RULE3 see RULE4
			end else begin
				st_next.cfg[GIOCFG_BIT_GPVAL] = st_reg.cfg[GIOCFG_BIT_GPVAL]; // see RULE2
			end
		end
		if (rd) begin
			st_next.rdata = {16'h0000, rv};
		end else if (psel & ~penable) begin
			st_next.rdata = GIOCFG_ZERO32;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_reg <= '{cfg: GIOCFG_RESET_VAL, pin_val: 1'b0, rdata: GIOCFG_ZERO32}; // see RULE9
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		pready            = 1'b1;
		pslverr           = psel & penable & ~hit;
		prdata            = (psel & penable & ~pwrite & hit) ? {16'h0000, rv} : GIOCFG_ZERO32;
		generic_io_pin_oe = st_reg.cfg[GIOCFG_BIT_GPDIR]; // see RULE1
		generic_io_pin_o  = st_reg.cfg[GIOCFG_BIT_GPDIR] & st_reg.cfg[GIOCFG_BIT_GPVAL]; // see RULE3 see RULE4
		rx_bus_oe         = gif.rx_oe;
		tx_bus_oe         = gif.tx_oe;
		wide_bus_alt_pins = gif.wide_alt_pins;
		config_out        = st_reg.cfg;
	end
endmodule
